// >>> logic/pms_supervisor.sv
// Power mode supervisor: regulators, thermal, modes, interrupt, reset
//
// Functional notes
// [R01] Aux regulator runs independent when track select is 0 (reset), tracks main when 1.
// [R02] Software sets tracking only when aux and main levels match.
// [R03] Voltage-select bit chooses aux level between 5 V and 3.3 V.
// [R04] Thermal stage one: high-sides, aux regulator, transmitters off; main stays on.
// [R05] Thermal stage one holds both transceivers receive-only.
// [R06] Thermal stage two: main off and every wake source disabled.
// [R07] Main restarts after delay; seven failures in a minute force battery standby.
// [R08] Regulator low beyond fail filter latches fail bit until clear command.
// [R09] Low beyond short-detect time after turn-on declares short, regulator off.
// [R10] Main short: battery standby, forced-sleep and main fail bits set.
// [R11] Aux short sets aux short and aux fail bits.
// [R12] Short detection ends once output rises above fail threshold.
// [R13] Debug high: watchdog off, all functions on, CAN enabled by default.
// [R14] Debug low again: watchdog restarts with long open window.
// [R15] Standby commands enter regulated standby at chip-select rise, long window starts.
// [R16] Regulated standby: watchdog off when load low, or at entry if monitor disabled.
// [R17] Monitor-disable write works only in first command after unlock; unlock then clears.
// [R18] Regulated standby: transmitters off, high-sides and aux keep programmed state.
// [R19] Wake returns to active and pulls interrupt; wake-only mode pulls interrupt only.
// [R20] Active interrupt follows five latched flags, each masked, masks shared.
// [R21] CAN silence beyond limit sets timeout flag and pulses interrupt unless masked.
// [R22] Load rise in regulated standby: stay, long window, no interrupt.
// [R23] Leaving battery standby holds reset low until 2 ms after main is up.
`timescale 1ns/1ps
module pms_supervisor #(
    parameter int unsigned THERMAL_RESTART_CYC = pms_pkg::THERMAL_RESTART_CYC_DEF,
    parameter int unsigned RESTART_WINDOW_CYC = pms_pkg::RESTART_WINDOW_CYC_DEF,
    parameter int unsigned FAIL_FILTER_CYC = pms_pkg::FAIL_FILTER_CYC_DEF,
    parameter int unsigned SHORT_DETECT_CYC = pms_pkg::SHORT_DETECT_CYC_DEF,
    parameter int unsigned SILENCE_CYC = pms_pkg::SILENCE_CYC_DEF,
    parameter int unsigned RESET_HOLD = pms_pkg::RESET_HOLD_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Pins and analog monitors (asynchronous)
    input wire logic chip_select_n_i,
    input wire logic debug_i,
    input wire logic thermal_stage_one_i,
    input wire logic thermal_stage_two_i,
    input wire logic main_below_fail_i,
    input wire logic aux_below_fail_i,
    input wire logic load_above_threshold_i,
    input wire logic can_activity_i,
    input wire logic wake_event_i,
    // Control bits from serial command decoder
    input wire logic cmd_done_i,
    input wire logic aux_track_select_i,
    input wire logic aux_voltage_select_i,
    input wire logic standby_kind_select_i,
    input wire logic standby_go_i,
    input wire logic load_monitor_disable_wr_i,
    input wire logic load_monitor_unlock_wr_i,
    input wire logic wake_interrupt_only_i,
    input wire logic fail_clear_i,
    input wire logic aux_enable_i,
    input wire logic [4:0] global_flags_i,
    input wire logic [4:0] flag_mask_i,
    input wire logic can_timeout_irq_mask_i,
    input wire logic wake_irq_mask_i,
    input wire logic can_timeout_clear_i,
    // Regulator and output controls
    output logic main_ldo_on_o,
    output logic aux_regulator_on_o,
    output logic aux_track_o,
    output logic aux_voltage_o,
    output logic outputs_allowed_o,
    output logic transceiver_tx_en_o,
    output logic transceiver_rx_only_o,
    output logic can_debug_enable_o,
    output logic wake_sources_en_o,
    // Watchdog control
    output logic watchdog_enable_o,
    output logic long_open_window_o,
    // Status
    output pms_pkg::pms_mode_t mode_o,
    output logic main_reg_fail_flag_o,
    output logic aux_reg_fail_flag_o,
    output logic aux_reg_short_flag_o,
    output logic forced_sleep_thermal_short_o,
    output logic can_timeout_flag_o,
    output logic load_monitor_disable_o,
    output logic load_monitor_unlock_o,
    output logic global_status_summary_o,
    // Open-drain pins and reset
    output logic interrupt_out_n_o,
    output logic interrupt_out_n_oe_o,
    output logic diag_out_n_o,
    output logic reset_out_n_o
);
    import pms_pkg::*;

    initial begin
        if (RESET_HOLD < 1 || FAIL_FILTER_CYC < 1 || SHORT_DETECT_CYC < 1 ||
            THERMAL_RESTART_CYC < 1 || SILENCE_CYC < 1 || RESTART_WINDOW_CYC < 1) begin
            $error("pms_supervisor: cycle counts must be at least 1");
        end
    end

    // Two-stage synchronisers for all pin-level inputs
    localparam int NS = 9;
    logic [NS-1:0] raw;
    logic [NS-1:0] s1_r;
    logic [NS-1:0] s2_r;
    assign raw = {chip_select_n_i, debug_i, thermal_stage_one_i, thermal_stage_two_i,
                  main_below_fail_i, aux_below_fail_i, load_above_threshold_i,
                  can_activity_i, wake_event_i};
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_r <= {1'b1, {(NS-1){1'b0}}};
            s2_r <= {1'b1, {(NS-1){1'b0}}};
        end else begin
            s1_r <= raw;
            s2_r <= s1_r;
        end
    end
    logic csn_s, dbg_s, ts1_s, ts2_s, mlow_s, alow_s, load_s, can_s, wake_s;
    assign {csn_s, dbg_s, ts1_s, ts2_s, mlow_s, alow_s, load_s, can_s, wake_s} = s2_r;

    // Registered state
    pms_mode_t mode_r, mode_nxt;
    logic csn_d_r, dbg_d_r;
    logic stby_pend_r, stby_pend_nxt, stby_kind_r, stby_kind_nxt;
    logic mfail_r, mfail_nxt, afail_r, afail_nxt, ashort_r, ashort_nxt;
    logic fsleep_r, fsleep_nxt, can_timeout_flag_r, can_timeout_flag_nxt;
    logic lmd_r, lmd_nxt, unl_r, unl_nxt;
    logic wd_en_r, wd_en_nxt, lw_r, lw_nxt;
    logic irq_r, irq_nxt, rst_n_r, rst_n_nxt, aux_on_r, aux_on_nxt;
    logic mdet_r, mdet_nxt, adet_r, adet_nxt, rst_hold_r, rst_hold_nxt;
    logic load_d_r;
    logic [2:0] rfail_r, rfail_nxt;
    logic [CNT_W-1:0] tmr_r, tmr_nxt, win_r, win_nxt, rcnt_r, rcnt_nxt;

    // Filters: fail filter, short detect, CAN silence
    logic mfail_hit, afail_hit, mshort_hit, ashort_hit, silence_hit;
    pms_filter #(.CYCLES(FAIL_FILTER_CYC)) u_mfail (
        .clk_i(clk_i), .rst_i(rst_i), .cond_i(mlow_s && main_ldo_on_o), .hit_o(mfail_hit));
    pms_filter #(.CYCLES(FAIL_FILTER_CYC)) u_afail (
        .clk_i(clk_i), .rst_i(rst_i), .cond_i(alow_s && aux_on_r), .hit_o(afail_hit));
    pms_filter #(.CYCLES(SHORT_DETECT_CYC)) u_mshort (
        .clk_i(clk_i), .rst_i(rst_i), .cond_i(mlow_s && mdet_r), .hit_o(mshort_hit));
    pms_filter #(.CYCLES(SHORT_DETECT_CYC)) u_ashort (
        .clk_i(clk_i), .rst_i(rst_i), .cond_i(alow_s && adet_r), .hit_o(ashort_hit));
    pms_filter #(.CYCLES(SILENCE_CYC)) u_silence (
        .clk_i(clk_i), .rst_i(rst_i),
        .cond_i(!can_s && (mode_r == PMS_ACTIVE || mode_r == PMS_REG_STBY)),
        .hit_o(silence_hit));

    logic csn_rise, dbg_fall, load_rise, can_timeout_flag_set, flags_hit;
    assign csn_rise = csn_s && !csn_d_r;
    assign dbg_fall = !dbg_s && dbg_d_r;
    assign load_rise = load_s && !load_d_r;
    assign can_timeout_flag_set = silence_hit && !can_timeout_flag_r;
    assign flags_hit = |(global_flags_i & ~flag_mask_i); // R20

    always_comb begin
        mode_nxt = mode_r;
        stby_pend_nxt = stby_pend_r;
        stby_kind_nxt = stby_kind_r;
        mfail_nxt = mfail_r;
        afail_nxt = afail_r;
        ashort_nxt = ashort_r;
        fsleep_nxt = fsleep_r;
        can_timeout_flag_nxt = can_timeout_flag_r;
        lmd_nxt = lmd_r;
        unl_nxt = unl_r;
        wd_en_nxt = wd_en_r;
        lw_nxt = 1'b0;
        irq_nxt = 1'b0;
        rst_n_nxt = rst_n_r;
        rst_hold_nxt = rst_hold_r;
        aux_on_nxt = aux_enable_i && !ashort_r;
        mdet_nxt = mdet_r;
        adet_nxt = adet_r;
        rfail_nxt = rfail_r;
        tmr_nxt = tmr_r;
        win_nxt = win_r;
        rcnt_nxt = rcnt_r;
        // Serial command side effects
        if (cmd_done_i) begin
            if (unl_r) begin
                unl_nxt = 1'b0; // R17
                if (load_monitor_disable_wr_i) lmd_nxt = 1'b1; // R17
            end else if (load_monitor_unlock_wr_i) begin
                unl_nxt = 1'b1;
            end
            if (standby_go_i) begin
                stby_pend_nxt = 1'b1;
                stby_kind_nxt = standby_kind_select_i;
            end
        end
        // Fail flags: clear loses to a fresh event
        if (fail_clear_i) begin
            mfail_nxt = 1'b0;
            afail_nxt = 1'b0;
            ashort_nxt = 1'b0;
            fsleep_nxt = 1'b0;
        end
        if (mfail_hit) mfail_nxt = 1'b1; // R08
        if (afail_hit) afail_nxt = 1'b1; // R08
        if (can_timeout_clear_i) can_timeout_flag_nxt = 1'b0;
        if (silence_hit) can_timeout_flag_nxt = 1'b1; // R21
        if (can_timeout_flag_set && !can_timeout_irq_mask_i) irq_nxt = 1'b1; // R21
        // Short detection window after turn-on
        if (!mlow_s) mdet_nxt = 1'b0; // R12
        if (!alow_s) adet_nxt = 1'b0; // R12
        if (aux_on_nxt && !aux_on_r) adet_nxt = 1'b1;
        if (ashort_hit) begin
            ashort_nxt = 1'b1; // R11
            afail_nxt = 1'b1; // R11
            aux_on_nxt = 1'b0; // R09
            adet_nxt = 1'b0;
        end
        if (!aux_enable_i) aux_on_nxt = 1'b0;
        // Reset output release counter
        if (rst_hold_r) begin
            if (mlow_s) begin
                tmr_nxt = '0;
            end else if (tmr_r >= CNT_W'(RESET_HOLD - 1)) begin
                rst_hold_nxt = 1'b0; // R23
                rst_n_nxt = 1'b1;
            end else begin
                tmr_nxt = tmr_r + CNT_W'(1);
            end
        end
        // Restart failure window
        if (rfail_r != 3'h0) begin
            if (rcnt_r >= CNT_W'(RESTART_WINDOW_CYC - 1)) begin
                rfail_nxt = 3'h0;
                rcnt_nxt = '0;
            end else begin
                rcnt_nxt = rcnt_r + CNT_W'(1);
            end
        end
        case (mode_r)
            PMS_ACTIVE, PMS_DEBUG, PMS_REG_STBY: begin
                if (mode_r == PMS_DEBUG && !dbg_s) begin
                    mode_nxt = PMS_ACTIVE;
                end
                if (mode_r == PMS_ACTIVE && dbg_s) begin
                    mode_nxt = PMS_DEBUG;
                    wd_en_nxt = 1'b0; // R13
                end
                if (dbg_fall) begin
                    wd_en_nxt = 1'b1; // R14
                    lw_nxt = 1'b1; // R14
                end
                if (mode_r != PMS_REG_STBY && stby_pend_r && csn_rise) begin
                    stby_pend_nxt = 1'b0;
                    if (stby_kind_r) begin
                        mode_nxt = PMS_BAT_STBY;
                        rst_n_nxt = 1'b0;
                        wd_en_nxt = 1'b0;
                    end else begin
                        mode_nxt = PMS_REG_STBY; // R15
                        wd_en_nxt = !lmd_r; // R16
                        lw_nxt = !lmd_r; // R15
                    end
                end
                if (mode_r == PMS_REG_STBY) begin
                    if (load_rise && !lmd_r) begin
                        wd_en_nxt = 1'b1; // R22
                        lw_nxt = 1'b1; // R22
                    end else if (!load_s && !lmd_r) begin
                        wd_en_nxt = 1'b0; // R16
                    end
                    if (wake_s) begin
                        if (!wake_irq_mask_i) irq_nxt = 1'b1; // R19
                        if (!wake_interrupt_only_i) begin
                            mode_nxt = PMS_ACTIVE; // R19
                            wd_en_nxt = 1'b1;
                            lw_nxt = 1'b1;
                        end
                    end
                end
                if (mshort_hit) begin
                    mode_nxt = PMS_BAT_STBY; // R10
                    fsleep_nxt = 1'b1; // R10
                    mfail_nxt = 1'b1; // R10
                    rst_n_nxt = 1'b0;
                    wd_en_nxt = 1'b0;
                    mdet_nxt = 1'b0;
                end else if (ts2_s) begin
                    mode_nxt = PMS_THERM_OFF; // R06
                    tmr_nxt = '0;
                    rst_n_nxt = 1'b0;
                    wd_en_nxt = 1'b0;
                end
            end
            PMS_THERM_OFF: begin
                if (ts2_s) begin
                    tmr_nxt = '0;
                end else if (tmr_r >= CNT_W'(THERMAL_RESTART_CYC - 1)) begin
                    if (rfail_r == RESTART_FAIL_MAX) begin
                        mode_nxt = PMS_BAT_STBY; // R07
                        fsleep_nxt = 1'b1; // R07
                    end else begin
                        mode_nxt = PMS_ACTIVE; // R07
                        rst_hold_nxt = 1'b1;
                        mdet_nxt = 1'b1;
                        wd_en_nxt = 1'b1;
                        lw_nxt = 1'b1;
                    end
                    rfail_nxt = rfail_r + 3'h1;
                    tmr_nxt = '0;
                end else begin
                    tmr_nxt = tmr_r + CNT_W'(1);
                end
            end
            PMS_BAT_STBY: begin
                if (wake_s) begin
                    mode_nxt = PMS_ACTIVE;
                    rst_hold_nxt = 1'b1; // R23
                    tmr_nxt = '0;
                    mdet_nxt = 1'b1;
                    wd_en_nxt = 1'b1;
                    lw_nxt = 1'b1;
                end
            end
            default: mode_nxt = PMS_ACTIVE;
        endcase
        if (mode_nxt == PMS_BAT_STBY || ts1_s) aux_on_nxt = 1'b0; // R04
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_r <= PMS_ACTIVE;
            csn_d_r <= 1'b1;
            dbg_d_r <= 1'b0;
            load_d_r <= 1'b0;
            stby_pend_r <= 1'b0;
            stby_kind_r <= 1'b0;
            mfail_r <= 1'b0;
            afail_r <= 1'b0;
            ashort_r <= 1'b0;
            fsleep_r <= 1'b0;
            can_timeout_flag_r <= 1'b0;
            lmd_r <= 1'b0;
            unl_r <= 1'b0;
            wd_en_r <= 1'b1;
            lw_r <= 1'b1;
            irq_r <= 1'b0;
            rst_n_r <= 1'b0;
            rst_hold_r <= 1'b1;
            aux_on_r <= 1'b0;
            mdet_r <= 1'b1;
            adet_r <= 1'b0;
            rfail_r <= 3'h0;
            tmr_r <= '0;
            win_r <= '0;
            rcnt_r <= '0;
        end else begin
            mode_r <= mode_nxt;
            csn_d_r <= csn_s;
            dbg_d_r <= dbg_s;
            load_d_r <= load_s;
            stby_pend_r <= stby_pend_nxt;
            stby_kind_r <= stby_kind_nxt;
            mfail_r <= mfail_nxt;
            afail_r <= afail_nxt;
            ashort_r <= ashort_nxt;
            fsleep_r <= fsleep_nxt;
            can_timeout_flag_r <= can_timeout_flag_nxt;
            lmd_r <= lmd_nxt;
            unl_r <= unl_nxt;
            wd_en_r <= wd_en_nxt;
            lw_r <= lw_nxt;
            irq_r <= irq_nxt;
            rst_n_r <= rst_n_nxt;
            rst_hold_r <= rst_hold_nxt;
            aux_on_r <= aux_on_nxt;
            mdet_r <= mdet_nxt;
            adet_r <= adet_nxt;
            rfail_r <= rfail_nxt;
            tmr_r <= tmr_nxt;
            win_r <= win_nxt;
            rcnt_r <= rcnt_nxt;
        end
    end

    // Outputs
    logic stby, therm_off, int_low;
    assign stby = (mode_r == PMS_REG_STBY) || (mode_r == PMS_BAT_STBY);
    assign therm_off = (mode_r == PMS_THERM_OFF);
    assign main_ldo_on_o = (mode_r != PMS_BAT_STBY) && !therm_off; // R06
    assign aux_regulator_on_o = aux_on_r; // R18
    assign aux_track_o = aux_track_select_i; // R01
    assign aux_voltage_o = aux_voltage_select_i; // R03
    assign outputs_allowed_o = !ts1_s && !therm_off && (mode_r != PMS_BAT_STBY); // R04
    assign transceiver_tx_en_o = !stby && !ts1_s && !therm_off; // R18
    assign transceiver_rx_only_o = ts1_s; // R05
    assign can_debug_enable_o = (mode_r == PMS_DEBUG); // R13
    assign wake_sources_en_o = !therm_off; // R06
    assign watchdog_enable_o = wd_en_r;
    assign long_open_window_o = lw_r;
    assign mode_o = mode_r;
    assign main_reg_fail_flag_o = mfail_r;
    assign aux_reg_fail_flag_o = afail_r;
    assign aux_reg_short_flag_o = ashort_r;
    assign forced_sleep_thermal_short_o = fsleep_r;
    assign can_timeout_flag_o = can_timeout_flag_r;
    assign load_monitor_disable_o = lmd_r;
    assign load_monitor_unlock_o = unl_r;
    assign global_status_summary_o = !flags_hit; // R20
    assign int_low = irq_r || (mode_r == PMS_ACTIVE && flags_hit); // R20
    assign interrupt_out_n_o = 1'b0;
    assign interrupt_out_n_oe_o = !int_low;
    assign diag_out_n_o = !flags_hit; // R20
    assign reset_out_n_o = rst_n_r;

    a_reset_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(rst_hold_r) |=> !reset_out_n_o) else $error("reset released early"); // R23
    a_thermal_two: assert property (@(posedge clk_i) disable iff (rst_i)
        therm_off |-> !main_ldo_on_o && !wake_sources_en_o)
        else $error("main on in thermal off"); // R06
    a_stage_one: assert property (@(posedge clk_i) disable iff (rst_i)
        ts1_s |-> !outputs_allowed_o && transceiver_rx_only_o && !transceiver_tx_en_o)
        else $error("stage one outputs active"); // R04
    a_aux_short: assert property (@(posedge clk_i) disable iff (rst_i)
        ashort_hit |=> aux_reg_short_flag_o && aux_reg_fail_flag_o && !aux_regulator_on_o)
        else $error("aux short not handled"); // R11
    a_main_short: assert property (@(posedge clk_i) disable iff (rst_i)
        (mshort_hit && mode_r == PMS_ACTIVE) |=> mode_r == PMS_BAT_STBY && fsleep_r && mfail_r)
        else $error("main short not handled"); // R10
    a_fail_latch: assert property (@(posedge clk_i) disable iff (rst_i)
        (mfail_r && !fail_clear_i) |=> mfail_r) else $error("fail flag dropped"); // R08
    a_unlock_once: assert property (@(posedge clk_i) disable iff (rst_i)
        (unl_r && cmd_done_i) |=> !unl_r) else $error("unlock not cleared"); // R17
    a_standby_entry: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode_r == PMS_ACTIVE && stby_pend_r && !stby_kind_r && csn_rise && !mshort_hit && !ts2_s)
        |=> mode_r == PMS_REG_STBY && !transceiver_tx_en_o)
        else $error("standby not entered"); // R15
    a_can_timeout_flag_irq: assert property (@(posedge clk_i) disable iff (rst_i)
        (can_timeout_flag_set && !can_timeout_irq_mask_i) |=> !interrupt_out_n_oe_o)
        else $error("timeout interrupt missing"); // R21
endmodule : pms_supervisor

// >>> logic/pms_pkg.sv
// Constants and types shared by the power mode supervisor
package pms_pkg;
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned RESET_HOLD_US = 2000;
    localparam int unsigned RESET_HOLD_CYC = (RESET_HOLD_US * (CLK_HZ / 1000000));
    localparam int unsigned THERMAL_RESTART_CYC_DEF = 1000000;
    localparam int unsigned RESTART_WINDOW_CYC_DEF = 1500000000;
    localparam int unsigned FAIL_FILTER_CYC_DEF = 250;
    localparam int unsigned SHORT_DETECT_CYC_DEF = 5000;
    localparam int unsigned SILENCE_CYC_DEF = 25000;
    localparam logic [2:0] RESTART_FAIL_MAX = 3'h7;
    localparam logic RST_TRACK = 1'b0;
    localparam logic RST_VSEL = 1'b0;
    localparam logic [4:0] RST_MASK = 5'h00;
    localparam int unsigned CNT_W = 32;

    typedef enum logic [2:0] {
        PMS_ACTIVE,
        PMS_DEBUG,
        PMS_REG_STBY,
        PMS_BAT_STBY,
        PMS_THERM_OFF
    } pms_mode_t;
endpackage : pms_pkg

// >>> logic/pms_filter.sv
// Persistence timer: asserts when a condition has held for a set number of cycles
`timescale 1ns/1ps
module pms_filter #(
    parameter int unsigned CYCLES = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Condition and result
    input wire logic cond_i,
    output logic hit_o
);
    import pms_pkg::*;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;

    initial begin
        if (CYCLES < 1) $error("pms_filter: CYCLES must be at least 1");
    end

    always_comb begin
        if (!cond_i) begin
            cnt_nxt = '0;
        end else if (cnt_r < CNT_W'(CYCLES)) begin
            cnt_nxt = cnt_r + CNT_W'(1);
        end else begin
            cnt_nxt = cnt_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign hit_o = cond_i && (cnt_r >= CNT_W'(CYCLES));
endmodule : pms_filter

// >>> test/pms_mcu_model.sv
// Controller side of the supervisor: pulled-up interrupt line, reset sense
`timescale 1ns/1ps
module pms_mcu_model (
    // Pins from the supervisor
    input wire logic irq_n_i,
    input wire logic irq_n_oe_i,
    input wire logic reset_n_i,
    // Levels seen by the controller
    output logic irq_line_o,
    output logic in_reset_o
);
    // Released open drain floats to the pull-up
    assign irq_line_o = irq_n_oe_i ? 1'b1 : irq_n_i;
    assign in_reset_o = ~reset_n_i;
endmodule : pms_mcu_model

// >>> test/testbench.sv
// Self-checking bench for the power mode supervisor
`timescale 1ns/1ps
module testbench;
    import pms_pkg::*;
    logic clk = 1'b0, rst = 1'b1, chip_select_n = 1'b1, dbg, th1, th2, mlow, alow, load, canact, wake;
    logic cdone, trk, vsel, kind, go, mdis, unl, wko, fclr, aen, wim, cim, cclr;
    logic [4:0] flg, msk;
    logic ldo, aon, atrk, avolt, outs, txen, rxo, wden, afail, irq, irq_oe, rstn, irq_line, inrst;
    logic gsum, can_timeout_flag, lmd, unlk;
    pms_mode_t mode;
    int failures = 0, num_checks = 0;
    always #20 clk = ~clk;
    pms_supervisor #(.THERMAL_RESTART_CYC(8), .RESTART_WINDOW_CYC(2000), .FAIL_FILTER_CYC(4),
        .SHORT_DETECT_CYC(10), .SILENCE_CYC(20), .RESET_HOLD(12)) u_dut (
        .clk_i(clk), .rst_i(rst), .chip_select_n_i(chip_select_n), .debug_i(dbg),
        .thermal_stage_one_i(th1), .thermal_stage_two_i(th2), .main_below_fail_i(mlow),
        .aux_below_fail_i(alow), .load_above_threshold_i(load), .can_activity_i(canact),
        .wake_event_i(wake), .cmd_done_i(cdone), .aux_track_select_i(trk),
        .aux_voltage_select_i(vsel), .standby_kind_select_i(kind), .standby_go_i(go),
        .load_monitor_disable_wr_i(mdis), .load_monitor_unlock_wr_i(unl),
        .wake_interrupt_only_i(wko), .fail_clear_i(fclr), .aux_enable_i(aen),
        .global_flags_i(flg), .flag_mask_i(msk), .can_timeout_irq_mask_i(cim),
        .wake_irq_mask_i(wim), .can_timeout_clear_i(cclr), .main_ldo_on_o(ldo),
        .aux_regulator_on_o(aon), .aux_track_o(atrk), .aux_voltage_o(avolt),
        .outputs_allowed_o(outs), .transceiver_tx_en_o(txen), .transceiver_rx_only_o(rxo),
        .can_debug_enable_o(), .wake_sources_en_o(), .watchdog_enable_o(wden),
        .long_open_window_o(), .mode_o(mode), .main_reg_fail_flag_o(),
        .aux_reg_fail_flag_o(afail), .aux_reg_short_flag_o(), .forced_sleep_thermal_short_o(),
        .can_timeout_flag_o(can_timeout_flag), .load_monitor_disable_o(lmd), .load_monitor_unlock_o(unlk),
        .global_status_summary_o(gsum), .interrupt_out_n_o(irq), .interrupt_out_n_oe_o(irq_oe),
        .diag_out_n_o(), .reset_out_n_o(rstn));
    pms_mcu_model u_mcu (.irq_n_i(irq), .irq_n_oe_i(irq_oe), .reset_n_i(rstn),
        .irq_line_o(irq_line), .in_reset_o(inrst));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim
    task automatic t_rails;
        cyc(30);
        chk(inrst, 1'b0);
        chk(atrk, 1'b0);
        vsel = 1'b1;
        trk = 1'b1;
        cyc(1);
        chk(atrk, 1'b1);
        chk(avolt, 1'b1);
        $display("rails done");
    endtask : t_rails
    task automatic t_fail;
        alow = 1'b1;
        cyc(12);
        chk(afail, 1'b1);
        alow = 1'b0;
        cyc(3);
        fclr = 1'b1;
        cyc(1);
        fclr = 1'b0;
        cyc(2);
        chk(afail, 1'b0);
        $display("fail flag done");
    endtask : t_fail
    task automatic t_mask;
        flg = 5'h04;
        cyc(2);
        chk(gsum, 1'b0);
        msk = 5'h04;
        cyc(2);
        chk(gsum, 1'b1);
        flg = 5'h00;
        $display("mask done");
    endtask : t_mask
    task automatic t_can_timeout_flag;
        bit low_seen;
        for (int m = 0; m < 2; m++) begin
            low_seen = 0;
            canact = 1'b1;
            cim = m[0];
            cyc(3);
            cclr = 1'b1;
            cyc(1);
            cclr = 1'b0;
            chk(can_timeout_flag, 1'b0);
            canact = 1'b0;
            for (int i = 0; i < 30; i++) begin
                cyc(1);
                if (irq_line === 1'b0) low_seen = 1;
            end
            chk(can_timeout_flag, 1'b1);
            chk(low_seen, !m[0]);
        end
        $display("can timeout done");
    endtask : t_can_timeout_flag
    task automatic t_standby;
        bit low_seen = 0;
        cdone = 1'b1;
        go = 1'b1;
        chip_select_n = 1'b0;
        cyc(1);
        cdone = 1'b0;
        go = 1'b0;
        cyc(1);
        chip_select_n = 1'b1;
        cyc(8);
        chk(8'(mode), 8'(PMS_REG_STBY));
        chk(txen, 1'b0);
        chk(aon, 1'b1);
        chk(wden, 1'b0);
        load = 1'b1;
        cyc(4);
        chk(wden, 1'b1);
        chk(irq_line, 1'b1);
        chk(8'(mode), 8'(PMS_REG_STBY));
        load = 1'b0;
        wake = 1'b1;
        for (int i = 0; i < 10; i++) begin
            cyc(1);
            if (irq_line === 1'b0) low_seen = 1;
        end
        wake = 1'b0;
        chk(low_seen, 1'b1);
        chk(8'(mode), 8'(PMS_ACTIVE));
        $display("standby done");
    endtask : t_standby
    task automatic t_unlock;
        mdis = 1'b1;
        cdone = 1'b1;
        cyc(1);
        chk(lmd, 1'b0);
        mdis = 1'b0;
        unl = 1'b1;
        cyc(1);
        chk(unlk, 1'b1);
        unl = 1'b0;
        mdis = 1'b1;
        cyc(1);
        cdone = 1'b0;
        mdis = 1'b0;
        chk(lmd, 1'b1);
        chk(unlk, 1'b0);
        $display("unlock done");
    endtask : t_unlock
    task automatic t_therm;
        th1 = 1'b1;
        cyc(5);
        chk({ldo, aon, outs, txen, rxo}, 5'b10001);
        th1 = 1'b0;
        dbg = 1'b1;
        cyc(5);
        chk(8'(mode), 8'(PMS_DEBUG));
        chk(wden, 1'b0);
        dbg = 1'b0;
        th2 = 1'b1;
        cyc(4);
        chk(ldo, 1'b0);
        chk(inrst, 1'b1);
        th2 = 1'b0;
        cyc(14);
        chk(8'(mode), 8'(PMS_ACTIVE));
        chk(inrst, 1'b1);
        cyc(12);
        chk(inrst, 1'b0);
        $display("thermal and debug done");
    endtask : t_therm
    initial begin
        {dbg, th1, th2, mlow, alow, load, canact, wake, cdone, kind, go, mdis, unl} = '0;
        {trk, vsel, wko, fclr, wim, cim, cclr} = '0;
        aen = 1'b1;
        flg = 5'h00;
        msk = 5'h00;
        cyc(6);
        rst = 1'b0;
        t_rails();
        t_fail();
        t_mask();
        t_can_timeout_flag();
        t_standby();
        t_unlock();
        t_therm();
        end_sim();
    end
    initial begin
        #(40 * 3000);
        failures++;
        end_sim();
    end
endmodule : testbench
